// [verilog/fps_flash_dev.sv]
// device end: flash blocks with cpu register port and external programming pins
`timescale 1ns/10ps
module fps_flash_dev import fps_pkg::*; #(
	parameter int PAGE_ERASE_CYC = FPS_PE_CYC, // shorten for simulation
	parameter int MASS_ERASE_CYC = FPS_ME_CYC,
	parameter logic [7:0] SIG0 = FPS_SIG0, // arbitrary value
	parameter logic [7:0] SIG1 = FPS_SIG1, // arbitrary value
	parameter logic [7:0] SIG2 = FPS_SIG2 // arbitrary value
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_sfr_rdata,
	output logic o_access_latched,
	fps_link_if.dev lk
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		fps_dst_t st;
		logic [7:0] page; // block bit and page number
		logic [5:0] offs; // byte within page
		logic [7:0] data;
		logic [7:0] cmd;
		logic [16:0] tmr; // self-timed operation counter
		logic [13:0] idx; // erase walk
		logic erdone;
		logic xlock; // external write targets the lock bits
		logic [2:0] lb; // lock bits, 0 = programmed
		logic access_lat; // access level caught at reset release while lock one is programmed
		logic rst_d;
		logic program_pulse_d;
		logic [7:0] rdata;
		logic [7:0] p0_o;
		logic p0_oe;
		logic rdy_o;
		logic rdy_oe;
		logic pull;
	} fps_dev_t;

	// the latch power-up value is arbitrary; zero is as good as any
	localparam fps_dev_t DEV_RST = '{st: FPS_D_IDLE, lb: FPS_LB_RST, rdy_o: 1'b1,
		pull: 1'b0, default: '0};

	fps_dev_t s_r;
	fps_dev_t s_nxt;
	logic [7:0] mem [0:FPS_ARRAY_BYTES-1]; // both blocks, block bit on top
	logic we; // array write this cycle
	logic [13:0] wa;
	logic [7:0] wd;
	logic [13:0] ca; // cpu address
	logic [13:0] xa; // pin address
	logic [7:0] rd_cpu;
	logic [7:0] rd_ext;
	logic ext; // external programming mode
	logic cmd_go;
	logic busy; // cpu operation running
	logic [2:0] mode;

	assign ca = fps_faddr(s_r.page, s_r.offs);
	assign xa = {lk.p2[5:0], lk.p1};
	assign rd_cpu = mem[ca];
	assign rd_ext = mem[xa];

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		we = 1'b0;
		wa = ca;
		wd = FPS_ERASED;
		// with lock one programmed only the latched access level counts
		ext = lk.pin_rst && (s_r.lb[0] ? lk.external_access_pin : s_r.access_lat);
		mode = {lk.p2[6], lk.p36, lk.p37};
		busy = (s_r.st == FPS_D_RD) || (s_r.st == FPS_D_WR) || (s_r.st == FPS_D_ERS);
		s_nxt.rst_d = lk.pin_rst;
		s_nxt.program_pulse_d = lk.program_pulse;
		s_nxt.pull = lk.pin_rst;

		// latch moves only on the falling edge of the reset pin
		if (s_r.rst_d && !lk.pin_rst && !s_r.lb[0]) begin
			s_nxt.access_lat = lk.external_access_pin;
		end

		// register writes land at once; only the command starts work
		if (i_sfr_wr) begin
			case (i_sfr_addr)
				FPS_SFR_OFFS: s_nxt.offs = i_sfr_wdata[5:0];
				FPS_SFR_PAGE: s_nxt.page = i_sfr_wdata;
				FPS_SFR_DATA: s_nxt.data = i_sfr_wdata;
				FPS_SFR_CMD: s_nxt.cmd = i_sfr_wdata;
				default: ;
			endcase
		end
		cmd_go = i_sfr_wr && (i_sfr_addr == FPS_SFR_CMD) && !ext;

		unique case (s_r.st)
			FPS_D_IDLE: begin
				// commands arriving while busy are not queued, they are lost
				if (cmd_go && i_sfr_wdata == FPS_CMD_READ) begin
					s_nxt.st = FPS_D_RD;
					s_nxt.tmr = 17'(FPS_RD_CYC - 1);
				end else if (cmd_go && i_sfr_wdata == FPS_CMD_WRITE) begin
					s_nxt.st = FPS_D_WR;
					s_nxt.tmr = 17'(FPS_WR_CYC - 1);
				end else if (cmd_go && i_sfr_wdata == FPS_CMD_ERASE) begin
					s_nxt.st = FPS_D_ERS;
					s_nxt.tmr = 17'(PAGE_ERASE_CYC - 1);
					s_nxt.idx = '0;
					s_nxt.erdone = 1'b0;
				end else if (ext && s_r.program_pulse_d && !lk.program_pulse && !lk.program_store_strobe) begin
					// falling program pulse with the store strobe low
					if (mode == FPS_MD_PGM && s_r.lb[0]) begin
						s_nxt.st = FPS_D_XWR;
						s_nxt.xlock = 1'b0;
					end else if (mode == FPS_MD_LCK) begin
						s_nxt.st = FPS_D_XWR;
						s_nxt.xlock = 1'b1;
					end else if (mode == FPS_MD_ERA) begin
						s_nxt.st = FPS_D_MAS;
						s_nxt.tmr = 17'(MASS_ERASE_CYC - 1);
						s_nxt.idx = '0;
						s_nxt.erdone = 1'b0;
					end
					s_nxt.page = {lk.p2[5:0], lk.p1[7:6]};
					s_nxt.offs = lk.p1[5:0];
					s_nxt.data = lk.p0;
					s_nxt.tmr = (mode == FPS_MD_ERA) ? 17'(MASS_ERASE_CYC - 1)
						: 17'(FPS_WR_CYC - 1);
				end
			end
			FPS_D_RD: begin
				if (s_r.tmr == '0) begin
					s_nxt.data = rd_cpu;
					s_nxt.st = FPS_D_IDLE;
				end else begin
					s_nxt.tmr = s_r.tmr - 17'h1;
				end
			end
			FPS_D_WR, FPS_D_XWR: begin
				// the cell can only lose ones, so the write is an and
				if (s_r.tmr == '0) begin
					if (s_r.st == FPS_D_XWR && s_r.xlock) begin
						s_nxt.lb = s_r.lb & s_r.data[2:0];
					end else begin
						we = 1'b1;
						wd = rd_cpu & s_r.data;
					end
					s_nxt.st = FPS_D_IDLE;
				end else begin
					s_nxt.tmr = s_r.tmr - 17'h1;
				end
			end
			FPS_D_ERS, FPS_D_MAS: begin
				// one byte a cycle; the timer normally outlasts the walk
				if (!s_r.erdone) begin
					we = 1'b1;
					wd = FPS_ERASED;
					if (s_r.st == FPS_D_ERS) begin
						wa = fps_faddr(s_r.page, s_r.idx[5:0]);
						s_nxt.erdone = (s_r.idx[5:0] == FPS_PAGE_LAST);
					end else begin
						wa = s_r.idx;
						s_nxt.erdone = (s_r.idx == FPS_ARRAY_LAST);
					end
					s_nxt.idx = s_r.idx + 14'h1;
				end
				if (s_r.tmr != '0) begin
					s_nxt.tmr = s_r.tmr - 17'h1;
				end else if (s_r.erdone) begin
					if (s_r.st == FPS_D_MAS) begin
						s_nxt.lb = FPS_LB_RST;
					end
					s_nxt.st = FPS_D_IDLE;
				end
			end
			default: s_nxt.st = FPS_D_IDLE;
		endcase

		// ready pin drives only in external mode, low while an external write or a mass erase runs
		s_nxt.rdy_oe = ext;
		s_nxt.rdy_o = !((s_nxt.st == FPS_D_XWR) || (s_nxt.st == FPS_D_MAS));

		// external readback while the read strobe on p2.7 is low
		s_nxt.p0_oe = 1'b0;
		s_nxt.p0_o = FPS_ERASED;
		if (ext && !lk.program_store_strobe && !lk.p2[7] && s_r.st == FPS_D_IDLE) begin
			if (mode == FPS_MD_SIG) begin
				// signatures are constants, so no erase can touch them
				s_nxt.p0_oe = 1'b1;
				case (lk.p1)
					FPS_SIG_A0: s_nxt.p0_o = SIG0;
					FPS_SIG_A1: s_nxt.p0_o = SIG1;
					FPS_SIG_A2: s_nxt.p0_o = SIG2;
					default: s_nxt.p0_o = FPS_ERASED;
				endcase
			end else if (mode == FPS_MD_VER) begin
				// parts with lock one or two programmed answer all ones; lock bits are never shown
				s_nxt.p0_oe = 1'b1;
				s_nxt.p0_o = (s_r.lb[0] && s_r.lb[1]) ? rd_ext : FPS_ERASED;
			end
		end

		// register read data, one cycle behind the address
		case (i_sfr_addr)
			FPS_SFR_OFFS: s_nxt.rdata = {2'b00, s_r.offs};
			FPS_SFR_PAGE: s_nxt.rdata = s_r.page;
			FPS_SFR_DATA: s_nxt.rdata = s_r.data;
			FPS_SFR_CMD: begin
				s_nxt.rdata = {2'b00, s_r.cmd[5:0]};
				s_nxt.rdata[FPS_RDY_HI_BIT] = !(busy && s_r.page[FPS_BLOCK_BIT]);
				s_nxt.rdata[FPS_RDY_LO_BIT] = !(busy && !s_r.page[FPS_BLOCK_BIT]);
			end
			default: s_nxt.rdata = 8'h00;
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_r <= DEV_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// array contents survive reset, as a flash would
	always_ff @(posedge i_mclk) begin
		if (we) begin
			mem[wa] <= wd;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_sfr_rdata = s_r.rdata;
	assign o_access_latched = s_r.access_lat;
	assign lk.pull_en = s_r.pull;
	assign lk.p0_d_o = s_r.p0_o;
	assign lk.p0_d_oe = s_r.p0_oe;
	assign lk.rdy_o = s_r.rdy_o;
	assign lk.rdy_oe = s_r.rdy_oe;

endmodule

// [common/fps_pkg.sv]
// constants, types and helpers shared by both ends of the flash program/erase sequencer
package fps_pkg;

	// ----------------------------------------
	// cpu special function register offsets
	// ----------------------------------------
	localparam logic [7:0] FPS_SFR_OFFS = 8'hea; // flash_byte_offset
	localparam logic [7:0] FPS_SFR_PAGE = 8'heb; // flash_page_address
	localparam logic [7:0] FPS_SFR_DATA = 8'hec; // flash_data_byte
	localparam logic [7:0] FPS_SFR_CMD = 8'hed; // flash_command_status
	localparam int FPS_RDY_HI_BIT = 7; // upper_block_ready
	localparam int FPS_RDY_LO_BIT = 6; // lower_block_ready
	localparam int FPS_BLOCK_BIT = 7; // block select in page address

	// ----------------------------------------
	// command codes and array geometry
	// ----------------------------------------
	localparam logic [7:0] FPS_CMD_READ = 8'haa;
	localparam logic [7:0] FPS_CMD_WRITE = 8'h55;
	localparam logic [7:0] FPS_CMD_ERASE = 8'h5a;
	localparam int FPS_ARRAY_BYTES = 16384; // two 8-kbyte blocks
	localparam logic [5:0] FPS_PAGE_LAST = 6'h3f; // 64 bytes to a page
	localparam logic [13:0] FPS_ARRAY_LAST = 14'h3fff;
	localparam logic [7:0] FPS_ERASED = 8'hff;
	localparam logic [2:0] FPS_LB_RST = 3'h7; // all lock bits unprogrammed

	// ----------------------------------------
	// signature bytes: values are arbitrary
	// ----------------------------------------
	localparam logic [7:0] FPS_SIG_A0 = 8'h30;
	localparam logic [7:0] FPS_SIG_A1 = 8'h31;
	localparam logic [7:0] FPS_SIG_A2 = 8'h32;
	localparam logic [7:0] FPS_SIG0 = 8'h11;
	localparam logic [7:0] FPS_SIG1 = 8'h22;
	localparam logic [7:0] FPS_SIG2 = 8'h33;

	// ----------------------------------------
	// external mode pins {p2.6, p3.6, p3.7}
	// ----------------------------------------
	localparam logic [2:0] FPS_MD_SIG = 3'h0; // p2.7 is the read strobe
	localparam logic [2:0] FPS_MD_VER = 3'h1;
	localparam logic [2:0] FPS_MD_ERA = 3'h4;
	localparam logic [2:0] FPS_MD_PGM = 3'h6;
	localparam logic [2:0] FPS_MD_LCK = 3'h7;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int FPS_CLK_NS = 100; // 10 MHz
	localparam int FPS_WR_NS = 63000;
	localparam int FPS_WR_CYC = FPS_WR_NS / FPS_CLK_NS;
	localparam int FPS_PE_NS = 9400000;
	localparam int FPS_PE_CYC = FPS_PE_NS / FPS_CLK_NS;
	localparam int FPS_ME_CYC = FPS_PE_CYC; // mass erase: same as page erase
	localparam int FPS_SETTLE_NS = 10000000;
	localparam int FPS_SETTLE_CYC = (FPS_SETTLE_NS + FPS_CLK_NS - 1) / FPS_CLK_NS;
	localparam int FPS_RD_CYC = 2; // inside one four-clock instruction cycle
	localparam int FPS_P27L_CYC = 10;
	localparam int FPS_P27H_CYC = 3;
	localparam int FPS_SETUP_CYC = 3;
	localparam int FPS_PROGL_CYC = 10;

	// ----------------------------------------
	// programmer avalon registers and operations
	// ----------------------------------------
	localparam logic [3:0] FPS_AV_CTRL = 4'h0; // w: op, r: status
	localparam logic [3:0] FPS_AV_ADDR = 4'h4; // [13] block, [12:0] address
	localparam logic [3:0] FPS_AV_WDAT = 4'h8;
	localparam logic [3:0] FPS_AV_RDAT = 4'hc;
	localparam logic [2:0] FPS_OP_PWR = 3'h1;
	localparam logic [2:0] FPS_OP_PGM = 3'h2;
	localparam logic [2:0] FPS_OP_VER = 3'h3;
	localparam logic [2:0] FPS_OP_SIG = 3'h4;
	localparam logic [2:0] FPS_OP_ERA = 3'h5;
	localparam logic [2:0] FPS_OP_LCK = 3'h6;
	localparam logic [2:0] FPS_OP_EXIT = 3'h7;

	typedef enum logic [2:0] {
		FPS_D_IDLE = 3'b000,
		FPS_D_RD = 3'b001,
		FPS_D_WR = 3'b011,
		FPS_D_ERS = 3'b010,
		FPS_D_MAS = 3'b110,
		FPS_D_XWR = 3'b100
	} fps_dst_t;

	typedef enum logic [3:0] {
		FPS_H_OFF = 4'b0000,
		FPS_H_SETL = 4'b0001,
		FPS_H_IDLE = 4'b0011,
		FPS_H_SETUP = 4'b0010,
		FPS_H_PLOW = 4'b0110,
		FPS_H_RLOW = 4'b0111,
		FPS_H_RHIGH = 4'b0101,
		FPS_H_X1 = 4'b0100,
		FPS_H_X2 = 4'b1100
	} fps_hst_t;

	// flat array address from page (with block bit) and byte offset
	function automatic logic [13:0] fps_faddr(input logic [7:0] pg, input logic [5:0] of);
		return {pg, of};
	endfunction

endpackage

// [common/fps_link_if.sv]
// pin-level link between the external programmer and the flash device
`timescale 1ns/10ps
interface fps_link_if;
	// programmer drives
	logic pin_rst; // reset pin, high holds the device in reset
	logic external_access_pin; // high selects external programming
	logic store_o; // program_store_strobe as driven
	logic store_oe;
	logic program_pulse_o; // program_pulse
	logic program_pulse_oe;
	logic port_oe; // ports 1, 2 and p3.6/7 driven
	logic [7:0] p1_o;
	logic [7:0] p2_o;
	logic p36_o;
	logic p37_o;
	logic [7:0] p0_h_o;
	logic p0_h_oe;
	// device drives
	logic pull_en; // weak pull-ups active
	logic [7:0] p0_d_o;
	logic p0_d_oe;
	logic rdy_o; // ready on p3.4
	logic rdy_oe;
	// resolved pin levels
	logic program_store_strobe;
	logic program_pulse;
	logic [7:0] p1;
	logic [7:0] p2;
	logic p36;
	logic p37;
	logic [7:0] p0;
	logic rdy;

	// undriven strobes and ports follow the weak pull-ups; port 0 has external ones
	assign program_store_strobe = store_oe ? store_o : pull_en;
	assign program_pulse = program_pulse_oe ? program_pulse_o : pull_en;
	assign p1 = port_oe ? p1_o : {8{pull_en}};
	assign p2 = port_oe ? p2_o : {8{pull_en}};
	assign p36 = port_oe ? p36_o : pull_en;
	assign p37 = port_oe ? p37_o : pull_en;
	assign p0 = p0_d_oe ? p0_d_o : (p0_h_oe ? p0_h_o : 8'hff);
	assign rdy = rdy_oe ? rdy_o : pull_en;

	modport dev (
		input pin_rst, external_access_pin, program_store_strobe, program_pulse, p1, p2, p36, p37, p0,
		output pull_en, p0_d_o, p0_d_oe, rdy_o, rdy_oe
	);
	modport host (
		input rdy, p0,
		output pin_rst, external_access_pin, store_o, store_oe, program_pulse_o, program_pulse_oe, port_oe,
		output p1_o, p2_o, p36_o, p37_o, p0_h_o, p0_h_oe
	);
endinterface

// [verilog/fps_program_pulse_host.sv]
// programmer end: avalon-controlled sequencer for the external programming pins
`timescale 1ns/10ps
module fps_program_pulse_host import fps_pkg::*; #(
	parameter int SETTLE_CYC = FPS_SETTLE_CYC // shorten for simulation
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	fps_link_if.host lk
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		fps_hst_t st;
		logic [16:0] cnt;
		logic [2:0] op;
		logic [13:0] addr;
		logic [7:0] wdat;
		logic [7:0] rdat;
		logic powered;
		logic wreq; // waitrequest
		logic [31:0] rd;
		logic pin_rst;
		logic access; // external access pin level
		logic store_o;
		logic store_oe;
		logic program_pulse_o;
		logic program_pulse_oe;
		logic port_oe;
		logic p27; // read strobe
		logic [2:0] mode;
		logic p0_oe;
	} fps_hst_reg_t;

	localparam fps_hst_reg_t HST_RST = '{st: FPS_H_OFF, wreq: 1'b1, p27: 1'b1,
		default: '0};

	fps_hst_reg_t s_r;
	fps_hst_reg_t s_nxt;
	logic acc; // bus access completes this edge
	logic go; // operation written
	logic rd_op;

	always_comb begin
		s_nxt = s_r;
		// one wait state: answer the cycle after the request shows
		s_nxt.wreq = 1'b1;
		acc = (i_avs_read || i_avs_write) && !s_r.wreq;
		if ((i_avs_read || i_avs_write) && s_r.wreq) begin
			s_nxt.wreq = 1'b0;
			case (i_avs_address)
				FPS_AV_CTRL: s_nxt.rd = {28'h0, lk.rdy, s_r.powered,
					(s_r.st != FPS_H_IDLE) && (s_r.st != FPS_H_OFF), 1'b0};
				FPS_AV_ADDR: s_nxt.rd = {18'h0, s_r.addr};
				FPS_AV_WDAT: s_nxt.rd = {24'h0, s_r.wdat};
				FPS_AV_RDAT: s_nxt.rd = {24'h0, s_r.rdat};
				default: s_nxt.rd = 32'h0;
			endcase
		end
		go = acc && i_avs_write && (i_avs_address == FPS_AV_CTRL);
		if (acc && i_avs_write && i_avs_address == FPS_AV_ADDR) begin
			s_nxt.addr = i_avs_writedata[13:0];
		end
		if (acc && i_avs_write && i_avs_address == FPS_AV_WDAT) begin
			s_nxt.wdat = i_avs_writedata[7:0];
		end
		rd_op = (s_r.op == FPS_OP_VER) || (s_r.op == FPS_OP_SIG);

		unique case (s_r.st)
			FPS_H_OFF: begin
				if (go && i_avs_writedata[2:0] == FPS_OP_PWR) begin
					s_nxt.pin_rst = 1'b1;
					s_nxt.cnt = 17'(SETTLE_CYC - 1);
					s_nxt.st = FPS_H_SETL;
				end
			end
			FPS_H_SETL: begin
				// nothing touches the pins until the device has settled
				if (s_r.cnt == '0) begin
					s_nxt.powered = 1'b1;
					s_nxt.st = FPS_H_IDLE;
				end else begin
					s_nxt.cnt = s_r.cnt - 17'h1;
				end
			end
			FPS_H_IDLE: begin
				if (go && i_avs_writedata[2:0] == FPS_OP_EXIT) begin
					s_nxt.store_oe = 1'b0;
					s_nxt.program_pulse_oe = 1'b0;
					s_nxt.st = FPS_H_X1;
				end else if (go && i_avs_writedata[2:0] != FPS_OP_PWR) begin
					s_nxt.op = i_avs_writedata[2:0];
					s_nxt.access = 1'b1;
					s_nxt.store_o = 1'b0;
					s_nxt.store_oe = 1'b1;
					s_nxt.program_pulse_o = 1'b1;
					s_nxt.program_pulse_oe = 1'b1;
					s_nxt.port_oe = 1'b1;
					s_nxt.p27 = 1'b1;
					s_nxt.p0_oe = (i_avs_writedata[2:0] == FPS_OP_PGM)
						|| (i_avs_writedata[2:0] == FPS_OP_LCK);
					case (i_avs_writedata[2:0])
						FPS_OP_PGM: s_nxt.mode = FPS_MD_PGM;
						FPS_OP_VER: s_nxt.mode = FPS_MD_VER;
						FPS_OP_ERA: s_nxt.mode = FPS_MD_ERA;
						FPS_OP_LCK: s_nxt.mode = FPS_MD_LCK;
						default: s_nxt.mode = FPS_MD_SIG;
					endcase
					s_nxt.cnt = 17'(FPS_SETUP_CYC - 1);
					s_nxt.st = FPS_H_SETUP;
				end
			end
			FPS_H_SETUP: begin
				if (s_r.cnt != '0) begin
					s_nxt.cnt = s_r.cnt - 17'h1;
				end else if (rd_op) begin
					s_nxt.p27 = 1'b0;
					s_nxt.cnt = 17'(FPS_P27L_CYC - 1);
					s_nxt.st = FPS_H_RLOW;
				end else begin
					s_nxt.program_pulse_o = 1'b0;
					s_nxt.cnt = 17'(FPS_PROGL_CYC - 1);
					s_nxt.st = FPS_H_PLOW;
				end
			end
			FPS_H_PLOW: begin
				// the minimum low time covers the device's ready latency
				if (s_r.cnt != '0) begin
					s_nxt.cnt = s_r.cnt - 17'h1;
				end else if (lk.rdy) begin
					s_nxt.program_pulse_o = 1'b1;
					s_nxt.st = FPS_H_IDLE;
				end
			end
			FPS_H_RLOW: begin
				if (s_r.cnt != '0) begin
					s_nxt.cnt = s_r.cnt - 17'h1;
				end else begin
					s_nxt.rdat = lk.p0;
					s_nxt.p27 = 1'b1;
					s_nxt.cnt = 17'(FPS_P27H_CYC - 1);
					s_nxt.st = FPS_H_RHIGH;
				end
			end
			FPS_H_RHIGH: begin
				if (s_r.cnt != '0) begin
					s_nxt.cnt = s_r.cnt - 17'h1;
				end else begin
					s_nxt.st = FPS_H_IDLE;
				end
			end
			FPS_H_X1: begin
				s_nxt.access = 1'b0;
				s_nxt.st = FPS_H_X2;
			end
			FPS_H_X2: begin
				s_nxt.port_oe = 1'b0;
				s_nxt.p0_oe = 1'b0;
				s_nxt.pin_rst = 1'b0;
				s_nxt.powered = 1'b0;
				s_nxt.st = FPS_H_OFF;
			end
			default: s_nxt.st = FPS_H_OFF;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_r <= HST_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_avs_readdata = s_r.rd;
	assign o_avs_waitrequest = s_r.wreq;
	assign lk.pin_rst = s_r.pin_rst;
	assign lk.external_access_pin = s_r.access;
	assign lk.store_o = s_r.store_o;
	assign lk.store_oe = s_r.store_oe;
	assign lk.program_pulse_o = s_r.program_pulse_o;
	assign lk.program_pulse_oe = s_r.program_pulse_oe;
	assign lk.port_oe = s_r.port_oe;
	assign lk.p1_o = s_r.addr[7:0];
	assign lk.p2_o = {s_r.p27, s_r.mode[2], s_r.addr[13:8]};
	assign lk.p36_o = s_r.mode[1];
	assign lk.p37_o = s_r.mode[0];
	assign lk.p0_h_o = s_r.wdat;
	assign lk.p0_h_oe = s_r.p0_oe;

endmodule

// [testbench/fps_link_props.sv]
// concurrent checks on the pin link between programmer and device
`timescale 1ns/10ps
module fps_link_props import fps_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic pin_rst,
	input wire logic external_access_pin,
	input wire logic program_store_strobe,
	input wire logic program_pulse,
	input wire logic [7:0] p2,
	input wire logic p36,
	input wire logic p37,
	input wire logic pull_en,
	input wire logic p0_d_oe,
	input wire logic rdy,
	input wire logic rdy_oe
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic [2:0] md; // mode pins as the device decodes them
	logic [15:0] low_r; // cycles the ready pin has been low
	logic go; // program pulse low with the store strobe low in external mode
	assign md = {p2[6], p36, p37};
	assign go = !program_pulse && !program_store_strobe && external_access_pin && pin_rst;
	// 16 bits hold a full mass-erase walk without wrapping
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			low_r <= 16'h0;
		end else begin
			low_r <= rdy ? 16'h0 : low_r + 16'h1;
		end
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_pull_reset: assert property (pin_rst [*3] |-> pull_en)
		else $error("pull-ups off while reset pin held");
	a_rdy_only_ext: assert property ((!pin_rst) [*3] |-> !rdy_oe)
		else $error("ready driven outside external mode");
	a_program_pulse_rdy_low: assert property ($fell(program_pulse) && go && md == FPS_MD_PGM |-> ##[1:2] !rdy)
		else $error("ready not low after program pulse");
	a_erase_rdy_low: assert property ($fell(program_pulse) && go && md == FPS_MD_ERA |-> ##[1:2] !rdy)
		else $error("ready not low after erase pulse");
	a_write_time: assert property ($rose(rdy) && md == FPS_MD_PGM |-> low_r inside {[628:632]})
		else $error("byte write time wrong");
	a_mass_length: assert property ($rose(rdy) && md == FPS_MD_ERA |-> low_r >= 16'h4000)
		else $error("mass erase ended before array walk");
	a_read_cause: assert property ($rose(p0_d_oe) |->
		!$past(p2[7]) && !$past(program_store_strobe))
		else $error("port 0 driven without read strobe");
	a_read_release: assert property ($rose(p2[7]) |-> ##2 !p0_d_oe)
		else $error("port 0 still driven after read strobe");
	c_program_pulse: cover property ($rose(rdy) && md == FPS_MD_PGM);
	c_erase: cover property ($rose(rdy) && md == FPS_MD_ERA);
	c_read: cover property ($rose(p0_d_oe));
endmodule

// [testbench/flash_program_erase_sequencer_bench.sv]
// self-checking bench: cpu commands, then external programming over the link
`timescale 1ns/10ps
module flash_program_erase_sequencer_bench import fps_pkg::*;;
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h0;
	logic sfr_wr = 1'b0;
	logic [7:0] sfr_wdata = 8'h0;
	logic [7:0] sfr_rdata;
	logic access_latched;
	logic [3:0] av_addr = 4'h0;
	logic av_rd = 1'b0;
	logic av_wr = 1'b0;
	logic [31:0] av_wd = 32'h0;
	logic [31:0] av_rdata;
	logic av_wait;
	logic [31:0] rv; // last value read back
	int miscompares = 0;
	int samples_checked = 0;
	fps_link_if lk();
	always #50 i_mclk = ~i_mclk;
	// short erase counts keep the run brief
	fps_flash_dev #(.PAGE_ERASE_CYC(100), .MASS_ERASE_CYC(50)) i_fps_flash_dev (
		.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sfr_addr(sfr_addr), .i_sfr_wr(sfr_wr),
		.i_sfr_wdata(sfr_wdata), .o_sfr_rdata(sfr_rdata),
		.o_access_latched(access_latched), .lk(lk));
	fps_program_pulse_host #(.SETTLE_CYC(20)) i_fps_program_pulse_host (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
		.i_avs_writedata(av_wd), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait), .lk(lk));
	fps_link_props i_fps_link_props (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .pin_rst(lk.pin_rst),
		.external_access_pin(lk.external_access_pin),
		.program_store_strobe(lk.program_store_strobe), .program_pulse(lk.program_pulse), .p2(lk.p2),
		.p36(lk.p36), .p37(lk.p37),
		.pull_en(lk.pull_en), .p0_d_oe(lk.p0_d_oe), .rdy(lk.rdy), .rdy_oe(lk.rdy_oe));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: saw %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic sfr_put(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge i_mclk);
		sfr_wr <= 1'b0;
	endtask
	// read data is registered one cycle after the address
	task automatic sfr_rd(input logic [7:0] a);
		@(posedge i_mclk);
		sfr_addr <= a;
		repeat (2) @(posedge i_mclk);
		#1 rv = {24'h0, sfr_rdata};
	endtask
	// the bench fetches no code from either block, so any block may be commanded
	task automatic cpu(input logic [7:0] pg, input logic [7:0] of, input logic [7:0] d,
		input logic [7:0] c);
		sfr_put(FPS_SFR_PAGE, pg);
		sfr_put(FPS_SFR_OFFS, of);
		sfr_put(FPS_SFR_DATA, d);
		sfr_put(FPS_SFR_CMD, c);
	endtask
	task automatic sfr_idle();
		for (int n = 0; n < 2000; n++) begin
			sfr_rd(FPS_SFR_CMD);
			if (rv[7:6] === 2'b11) return;
		end
		miscompares++;
		report_and_stop();
	endtask
	// data register is cleared first so a dead read cannot pass
	task automatic cpu_read(input logic [7:0] pg, input logic [7:0] of, input logic [7:0] e);
		cpu(pg, of, 8'h00, FPS_CMD_READ);
		@(posedge i_mclk);
		sfr_rd(FPS_SFR_DATA);
		chk(rv, {24'h0, e});
	endtask
	// avalon access: request held until waitrequest is sampled low
	task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		av_addr <= a;
		av_wd <= d;
		av_wr <= w;
		av_rd <= ~w;
		for (int n = 0; n < 50; n++) begin
			@(posedge i_mclk);
			if (av_wait === 1'b0) begin
				rv = av_rdata;
				av_wr <= 1'b0;
				av_rd <= 1'b0;
				return;
			end
		end
		miscompares++;
		report_and_stop();
	endtask
	task automatic host_wait(input logic [31:0] m, input logic [31:0] v);
		for (int n = 0; n < 20000; n++) begin
			av(1'b0, FPS_AV_CTRL, 32'h0);
			if ((rv & m) === v) return;
		end
		miscompares++;
		report_and_stop();
	endtask
	task automatic ext(input logic [2:0] op, input logic [13:0] a, input logic [7:0] e);
		av(1'b1, FPS_AV_ADDR, {18'h0, a});
		av(1'b1, FPS_AV_WDAT, {24'h0, e});
		av(1'b1, FPS_AV_CTRL, {29'h0, op});
		host_wait(32'h2, 32'h0);
		av(1'b0, FPS_AV_RDAT, 32'h0);
		if (op == FPS_OP_VER || op == FPS_OP_SIG) chk(rv & 32'hff, {24'h0, e});
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic s_cpu();
		chk({31'h0, access_latched}, 32'h0);
		sfr_put(FPS_SFR_OFFS, 8'hff);
		sfr_rd(FPS_SFR_OFFS);
		chk(rv, 32'h3f);
		cpu(8'h01, 8'h05, 8'h00, FPS_CMD_ERASE);
		sfr_rd(FPS_SFR_CMD);
		chk(rv & 32'hc0, 32'h80);
		sfr_idle();
		cpu(8'h01, 8'h05, 8'ha5, FPS_CMD_WRITE);
		sfr_idle();
		// second and last write to this byte before the next erase
		cpu(8'h01, 8'h05, 8'h0f, FPS_CMD_WRITE);
		sfr_idle();
		cpu_read(8'h01, 8'h05, 8'h05);
		cpu_read(8'h01, 8'h06, 8'hff);
		cpu(8'h81, 8'h00, 8'h00, FPS_CMD_ERASE);
		sfr_rd(FPS_SFR_CMD);
		chk(rv & 32'hc0, 32'h40);
		sfr_idle();
	endtask
	task automatic s_ext();
		av(1'b1, FPS_AV_CTRL, {29'h0, FPS_OP_PWR});
		host_wait(32'h4, 32'h4);
		ext(FPS_OP_ERA, 14'h0, 8'h0);
		ext(FPS_OP_VER, 14'h0045, 8'hff);
		ext(FPS_OP_PGM, 14'h2123, 8'h3c);
		ext(FPS_OP_VER, 14'h2123, 8'h3c);
		ext(FPS_OP_VER, 14'h0123, 8'hff);
		ext(FPS_OP_SIG, {6'h0, FPS_SIG_A0}, FPS_SIG0);
		ext(FPS_OP_SIG, {6'h0, FPS_SIG_A1}, FPS_SIG1);
		ext(FPS_OP_SIG, {6'h0, FPS_SIG_A2}, FPS_SIG2);
		// program lock one and two: the byte read above must no longer come back
		ext(FPS_OP_LCK, 14'h0, 8'hfc);
		ext(FPS_OP_VER, 14'h2123, 8'hff);
		av(1'b1, FPS_AV_CTRL, {29'h0, FPS_OP_EXIT});
		repeat (10) @(posedge i_mclk);
	endtask
	initial begin
		repeat (5) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		s_cpu();
		s_ext();
		report_and_stop();
	end
endmodule
